// ---- rtl/host_shared_flash_access_regs_regs.vh ----
// Register indices, field positions and reset values of the host shared flash access registers.
`ifndef HOST_SHARED_FLASH_ACCESS_REGS_REGS_VH
`define HOST_SHARED_FLASH_ACCESS_REGS_REGS_VH
`define IDX_ADDR_BYTE0 4'h0
`define IDX_ADDR_BYTE1 4'h1
`define IDX_ADDR_BYTE2 4'h2
`define IDX_ADDR_BYTE3 4'h3
`define IDX_DATA_PORT 4'h4
`define IDX_FLASH_CONTROL 4'h5
`define IDX_FLASH_STATUS 4'h6
`define IDX_PROTECT_LOW 4'h7
`define IDX_PROTECT_HIGH 4'h8
`define IDX_SEMAPHORE 4'hC
`define CTRL_PAGE_ERASE_BIT 5
`define STAT_ERASE_ERROR_BIT 0
`define STAT_PROGRAM_ERROR_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_BUFFER_FULL_BIT 3
`define STAT_DATA_LOSS_BIT 4
`define PROT_INDEX_MSB 7
`define PROT_INDEX_LSB 4
`define PROT_INDEX_WRITE_BIT 3
`define PROT_LOCK_BIT 2
`define CONTROL_RESET 8'h00
`define ADDR_BYTE_RESET 8'h00
`define SEM_RESET 8'h00
`define PROT_FLAGS_RESET 3'h2
`define PROT_INDEX_RESET 4'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- rtl/host_shared_flash_access_regs.v ----
// Host register set for indirect shared flash access and host/core semaphore, as an AXI4-Lite slave.
// Overview of operation
// - Semaphore is 8 bits; host writes low nibble, core writes high nibble.
// - Every host semaphore write sets the written flag toward the core.
// - With the core's enable set, a host semaphore write raises the core interrupt.
// - Four byte registers form the 32-bit indirect memory address.
// - The 8-bit data port carries the byte for each indirect access.
// - Control and status bits 0, 1 and 4 clear to zero on reset; status bits 2 and 3 follow the busy and buffer-full inputs.
// - With page erase set, a flash write erases the page at the address.
// - Status bit 0 flags an erase error; write one clears it.
// - Status bit 1 flags a program error; write one clears it.
// - The three error flags clear only while busy reads zero.
// - Status bit 2 reads one while a host flash operation runs.
// - Status bit 3 reads one while the write double buffer is full.
// - Status bit 4 flags a write to a full buffer; write one clears it.
// - These registers are decoded from the host bus only.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "host_shared_flash_access_regs_regs.vh"
module host_shared_flash_access_regs (
   input wire CLOCK,
   input wire RST,
   input wire [31:0] AWADDR,
   input wire [2:0] AWPROT,
   input wire AWVALID,
   output reg AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output reg WREADY,
   output reg [1:0] BRESP,
   output reg BVALID,
   input wire BREADY,
   input wire [31:0] ARADDR,
   input wire [2:0] ARPROT,
   input wire ARVALID,
   output reg ARREADY,
   output reg [31:0] RDATA,
   output reg [1:0] RRESP,
   output reg RVALID,
   input wire RREADY,
   input wire CORE_SEM_WE,
   input wire [3:0] CORE_SEM_WDATA,
   input wire CORE_SEM_FLAG_CLR,
   input wire HOST_SEM_IRQ_ENABLE,
   output reg [7:0] SEM_VALUE,
   output reg HOST_SEM_WRITTEN,
   output reg CORE_IRQ,
   output reg MEM_REQ,
   output reg MEM_WRITE,
   output reg MEM_ERASE,
   output reg [31:0] MEM_ADDR,
   output reg [7:0] MEM_WDATA,
   input wire MEM_ACK,
   input wire [7:0] MEM_RDATA,
   input wire FLASH_BUSY,
   input wire BUFFER_FULL,
   input wire ERASE_ERROR,
   input wire PROGRAM_ERROR
);

localparam S_IDLE = 3'h0;
localparam S_WACC = 3'h1;
localparam S_WMEM = 3'h2;
localparam S_BRESP = 3'h3;
localparam S_RACC = 3'h4;
localparam S_RMEM = 3'h5;
localparam S_RRESP = 3'h6;

reg [2:0] state;
reg [7:0] addr_byte0;
reg [7:0] addr_byte1;
reg [7:0] addr_byte2;
reg [7:0] addr_byte3;
reg [7:0] flash_control;
reg erase_error_flag;
reg program_error_flag;
reg data_loss_flag;
reg [3:0] prot_index_low;
reg [3:0] prot_index_high;
reg [2:0] prot_flags [0:31];
integer i;

// Only aligned words in the low 64 bytes that carry a register are mapped.
function mapped;
   input [31:0] a;
   begin
      mapped = 1'b0;
      if (a[1:0] == 2'h0 && a[31:6] == 26'h0)
      begin
         case (a[5:2])
            `IDX_ADDR_BYTE0, `IDX_ADDR_BYTE1, `IDX_ADDR_BYTE2, `IDX_ADDR_BYTE3,
            `IDX_DATA_PORT, `IDX_FLASH_CONTROL, `IDX_FLASH_STATUS,
            `IDX_PROTECT_LOW, `IDX_PROTECT_HIGH, `IDX_SEMAPHORE:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   end
endfunction

function [3:0] reg_index;
   input [31:0] a;
   begin
      reg_index = a[5:2];
   end
endfunction

// Busy comes from the flash side only; the block adds no pending-write term of its own.
wire host_busy = FLASH_BUSY;
wire do_write = (state == S_WACC) && mapped(AWADDR) && WSTRB[0];
wire [3:0] widx = reg_index(AWADDR);
wire [7:0] wbyte = WDATA[7:0];
wire stat_write = do_write && (widx == `IDX_FLASH_STATUS);
wire clear_ok = stat_write && !host_busy;
wire sem_write = do_write && (widx == `IDX_SEMAPHORE);
wire data_write = do_write && (widx == `IDX_DATA_PORT);
wire lost_write = data_write && BUFFER_FULL;
// A host write in the core's clearing cycle keeps the flag, so no write goes unseen.
wire next_sem_flag = sem_write || (HOST_SEM_WRITTEN && !CORE_SEM_FLAG_CLR);
wire [4:0] prot_low_sel = {1'b0, prot_index_low};
wire [4:0] prot_high_sel = {1'b1, prot_index_high};
wire [4:0] prot_new_sel = {widx == `IDX_PROTECT_HIGH, wbyte[`PROT_INDEX_MSB:`PROT_INDEX_LSB]};

reg [7:0] read_byte;

always @*
begin
   read_byte = 8'h00;
   case (reg_index(ARADDR))
      `IDX_ADDR_BYTE0:
         read_byte = addr_byte0;
      `IDX_ADDR_BYTE1:
         read_byte = addr_byte1;
      `IDX_ADDR_BYTE2:
         read_byte = addr_byte2;
      `IDX_ADDR_BYTE3:
         read_byte = addr_byte3;
      `IDX_FLASH_CONTROL:
         read_byte = flash_control;
      `IDX_FLASH_STATUS:
         read_byte = {3'h0, data_loss_flag, BUFFER_FULL, host_busy,
                      program_error_flag, erase_error_flag};
      `IDX_PROTECT_LOW:
         read_byte = {prot_index_low, 1'b0, prot_flags[prot_low_sel]};
      `IDX_PROTECT_HIGH:
         read_byte = {prot_index_high, 1'b0, prot_flags[prot_high_sel]};
      `IDX_SEMAPHORE:
         read_byte = SEM_VALUE;
      default:
         read_byte = 8'h00;
   endcase
end

// Bus handshake and indirect memory sequencing share one machine, so only one access is ever open.
always @(posedge CLOCK)
begin
   if (RST)
   begin
      state <= S_IDLE;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RRESP <= `RESP_OKAY;
      RDATA <= 32'h00000000;
      MEM_REQ <= 1'b0;
      MEM_WRITE <= 1'b0;
      MEM_ERASE <= 1'b0;
      MEM_ADDR <= 32'h00000000;
      MEM_WDATA <= 8'h00;
   end
   else
   begin
      case (state)
         S_IDLE:
         begin
            if (AWVALID && WVALID)
            begin
               AWREADY <= 1'b1;
               WREADY <= 1'b1;
               state <= S_WACC;
            end
            else if (ARVALID)
            begin
               ARREADY <= 1'b1;
               state <= S_RACC;
            end
         end
         S_WACC:
         begin
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BRESP <= mapped(AWADDR) ? `RESP_OKAY : `RESP_SLVERR;
            if (data_write && !lost_write)
            begin
               MEM_REQ <= 1'b1;
               MEM_WRITE <= 1'b1;
               MEM_ERASE <= flash_control[`CTRL_PAGE_ERASE_BIT];
               MEM_ADDR <= {addr_byte3, addr_byte2, addr_byte1, addr_byte0};
               MEM_WDATA <= wbyte;
               state <= S_WMEM;
            end
            else
            begin
               BVALID <= 1'b1;
               state <= S_BRESP;
            end
         end
         S_WMEM:
         begin
            if (MEM_ACK)
            begin
               MEM_REQ <= 1'b0;
               MEM_WRITE <= 1'b0;
               MEM_ERASE <= 1'b0;
               BVALID <= 1'b1;
               state <= S_BRESP;
            end
         end
         S_BRESP:
         begin
            if (BREADY)
            begin
               BVALID <= 1'b0;
               state <= S_IDLE;
            end
         end
         S_RACC:
         begin
            ARREADY <= 1'b0;
            if (mapped(ARADDR) && reg_index(ARADDR) == `IDX_DATA_PORT)
            begin
               MEM_REQ <= 1'b1;
               MEM_WRITE <= 1'b0;
               MEM_ERASE <= 1'b0;
               MEM_ADDR <= {addr_byte3, addr_byte2, addr_byte1, addr_byte0};
               state <= S_RMEM;
            end
            else
            begin
               // An unmapped read returns zero, so a misaligned access never aliases a real register.
               if (mapped(ARADDR))
                  RDATA <= {24'h000000, read_byte};
               else
                  RDATA <= 32'h00000000;
               RRESP <= mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
               RVALID <= 1'b1;
               state <= S_RRESP;
            end
         end
         S_RMEM:
         begin
            if (MEM_ACK)
            begin
               MEM_REQ <= 1'b0;
               RDATA <= {24'h000000, MEM_RDATA};
               RRESP <= `RESP_OKAY;
               RVALID <= 1'b1;
               state <= S_RRESP;
            end
         end
         S_RRESP:
         begin
            if (RREADY)
            begin
               RVALID <= 1'b0;
               state <= S_IDLE;
            end
         end
         default:
            state <= S_IDLE;
      endcase
   end
end

// Address bytes and control; the page erase bit is trusted to change only while idle.
always @(posedge CLOCK)
begin
   if (RST)
   begin
      addr_byte0 <= `ADDR_BYTE_RESET;
      addr_byte1 <= `ADDR_BYTE_RESET;
      addr_byte2 <= `ADDR_BYTE_RESET;
      addr_byte3 <= `ADDR_BYTE_RESET;
      flash_control <= `CONTROL_RESET;
   end
   else if (do_write)
   begin
      case (widx)
         `IDX_ADDR_BYTE0:
            addr_byte0 <= wbyte;
         `IDX_ADDR_BYTE1:
            addr_byte1 <= wbyte;
         `IDX_ADDR_BYTE2:
            addr_byte2 <= wbyte;
         `IDX_ADDR_BYTE3:
            addr_byte3 <= wbyte;
         `IDX_FLASH_CONTROL:
            flash_control <= {2'h0, wbyte[`CTRL_PAGE_ERASE_BIT], 5'h00};
         default:
            flash_control <= flash_control;
      endcase
   end
end

// Sticky error flags: a new event in the clearing cycle wins over the clear.
always @(posedge CLOCK)
begin
   if (RST)
   begin
      erase_error_flag <= 1'b0;
      program_error_flag <= 1'b0;
      data_loss_flag <= 1'b0;
   end
   else
   begin
      erase_error_flag <= ERASE_ERROR ||
         (erase_error_flag && !(clear_ok && wbyte[`STAT_ERASE_ERROR_BIT]));
      program_error_flag <= PROGRAM_ERROR ||
         (program_error_flag && !(clear_ok && wbyte[`STAT_PROGRAM_ERROR_BIT]));
      data_loss_flag <= lost_write ||
         (data_loss_flag && !(clear_ok && wbyte[`STAT_DATA_LOSS_BIT]));
   end
end

// Protection flags are kept for readback; a locked block ignores flag writes until reset.
always @(posedge CLOCK)
begin
   if (RST)
   begin
      prot_index_low <= `PROT_INDEX_RESET;
      prot_index_high <= `PROT_INDEX_RESET;
      for (i = 0; i < 32; i = i + 1)
         prot_flags[i] <= `PROT_FLAGS_RESET;
   end
   else if (do_write && (widx == `IDX_PROTECT_LOW || widx == `IDX_PROTECT_HIGH))
   begin
      if (widx == `IDX_PROTECT_LOW)
         prot_index_low <= wbyte[`PROT_INDEX_MSB:`PROT_INDEX_LSB];
      else
         prot_index_high <= wbyte[`PROT_INDEX_MSB:`PROT_INDEX_LSB];
      if (!wbyte[`PROT_INDEX_WRITE_BIT] && !prot_flags[prot_new_sel][`PROT_LOCK_BIT])
         prot_flags[prot_new_sel] <= wbyte[2:0];
   end
end

// Semaphore: each side owns one nibble, so both may write in the same cycle.
always @(posedge CLOCK)
begin
   if (RST)
   begin
      SEM_VALUE <= `SEM_RESET;
      HOST_SEM_WRITTEN <= 1'b0;
      CORE_IRQ <= 1'b0;
   end
   else
   begin
      if (sem_write)
         SEM_VALUE[3:0] <= wbyte[3:0];
      if (CORE_SEM_WE)
         SEM_VALUE[7:4] <= CORE_SEM_WDATA;
      HOST_SEM_WRITTEN <= next_sem_flag;
      CORE_IRQ <= HOST_SEM_IRQ_ENABLE && next_sem_flag;
   end
end

endmodule

// ---- tb/host_shared_flash_access_regs_properties.sv ----
// Concurrent checks on the host shared flash access register ports.
module host_shared_flash_access_regs_checker (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic [31:0] AWADDR,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic CORE_SEM_WE,
   input wire logic [3:0] CORE_SEM_WDATA,
   input wire logic HOST_SEM_IRQ_ENABLE,
   input wire logic [7:0] SEM_VALUE,
   input wire logic HOST_SEM_WRITTEN,
   input wire logic CORE_IRQ,
   input wire logic MEM_REQ,
   input wire logic MEM_ACK,
   input wire logic [31:0] MEM_ADDR
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic wr_go = AWVALID && AWREADY && WVALID && WREADY;
   wire logic sem_wr = wr_go && AWADDR == 32'h30 && WSTRB[0];
   wire logic bad = AWADDR[31:6] != 26'h0 || AWADDR[1:0] != 2'h0 || (AWADDR[5:2] > 4'h8 && AWADDR[5:2] != 4'hC);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   a_sem_host_low: assert property (sem_wr |=> SEM_VALUE[3:0] == $past(WDATA[3:0]))
      else $error("host semaphore bits wrong");
   a_sem_core_high: assert property (CORE_SEM_WE |=> SEM_VALUE[7:4] == $past(CORE_SEM_WDATA))
      else $error("core semaphore bits wrong");
   a_sem_upper_kept: assert property (!CORE_SEM_WE |=> $stable(SEM_VALUE[7:4]))
      else $error("upper semaphore bits changed without core write");
   a_flag_on_write: assert property (sem_wr |=> HOST_SEM_WRITTEN)
      else $error("semaphore written flag not set");
   a_irq_on_write: assert property (sem_wr && HOST_SEM_IRQ_ENABLE |=> CORE_IRQ)
      else $error("core interrupt not raised");
   a_mem_req_hold: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
      else $error("memory request dropped or address moved");
   a_unmapped_err: assert property (wr_go && bad |=> BVALID && BRESP == 2'h2)
      else $error("unmapped write not refused");
   a_mapped_okay: assert property (wr_go && !bad |-> ##[1:40] BVALID && BRESP == 2'h0)
      else $error("mapped write not answered okay");
   a_reset_idle: assert property (disable iff (1'b0) RST |=> !BVALID && !MEM_REQ && SEM_VALUE == 8'h00)
      else $error("outputs not cleared by reset");
   c_sem_irq: cover property (sem_wr && HOST_SEM_IRQ_ENABLE);
   c_unmapped: cover property (wr_go && bad);
   c_mem_ack: cover property (MEM_REQ && MEM_ACK);
endmodule
bind host_shared_flash_access_regs host_shared_flash_access_regs_checker u_chk (.CLOCK(CLOCK), .RST(RST),
   .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
   .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .CORE_SEM_WE(CORE_SEM_WE),
   .CORE_SEM_WDATA(CORE_SEM_WDATA), .HOST_SEM_IRQ_ENABLE(HOST_SEM_IRQ_ENABLE), .SEM_VALUE(SEM_VALUE),
   .HOST_SEM_WRITTEN(HOST_SEM_WRITTEN), .CORE_IRQ(CORE_IRQ), .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK),
   .MEM_ADDR(MEM_ADDR));

// ---- tb/flash_port_model.sv ----
// Behavioural flash access port answering the block's memory requests.
module flash_port_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic req,
   input wire logic we,
   input wire logic erase,
   input wire logic [31:0] addr,
   input wire logic [7:0] wdata,
   output logic ack,
   output logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] last_addr;
   logic [7:0] last_data;
   logic last_erase;
   int n_wr = 0;
   int delay = 0;
   int cnt;
   always @(posedge clk)
   begin
      if (rst)
      begin
         ack <= 1'b0;
         rdata <= 8'h00;
         cnt <= 0;
      end
      else if (req && !ack && cnt < delay)
         cnt <= cnt + 1;
      else if (req && !ack)
      begin
         // Read data is a fixed function of the address so the bench can predict it.
         ack <= 1'b1;
         rdata <= addr[7:0] ^ 8'hA5;
         cnt <= 0;
         if (we)
         begin
            last_addr <= addr;
            last_data <= wdata;
            last_erase <= erase;
            n_wr <= n_wr + 1;
         end
      end
      else
      begin
         // Outside an answer and its wait cycles the data lines carry the inverse of the last value; while waiting they hold it.
         ack <= 1'b0;
         rdata <= ~rdata;
      end
   end
endmodule

// ---- tb/host_shared_flash_access_regs_tb.sv ----
// Self-checking bench for the host shared flash access registers.
module host_shared_flash_access_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 0, RST = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic [31:0] AWADDR = '0, WDATA = '0, ARADDR = '0, RDATA, MEM_ADDR, d;
   logic [3:0] WSTRB = 4'hF, CORE_SEM_WDATA = 4'h0;
   logic CORE_SEM_WE = 0, CORE_SEM_FLAG_CLR = 0, HOST_SEM_IRQ_ENABLE = 0;
   logic FLASH_BUSY = 0, BUFFER_FULL = 0, ERASE_ERROR = 0, PROGRAM_ERROR = 0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID, HOST_SEM_WRITTEN, CORE_IRQ, MEM_REQ, MEM_WRITE, MEM_ERASE, MEM_ACK;
   logic [1:0] BRESP, RRESP, r;
   logic [7:0] SEM_VALUE, MEM_WDATA, MEM_RDATA;
   int err_count = 0;
   int n_checks = 0;
   host_shared_flash_access_regs u_dut (.CLOCK(CLOCK), .RST(RST), .AWADDR(AWADDR), .AWPROT(3'h0),
      .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .CORE_SEM_WE(CORE_SEM_WE), .CORE_SEM_WDATA(CORE_SEM_WDATA), .CORE_SEM_FLAG_CLR(CORE_SEM_FLAG_CLR),
      .HOST_SEM_IRQ_ENABLE(HOST_SEM_IRQ_ENABLE), .SEM_VALUE(SEM_VALUE), .HOST_SEM_WRITTEN(HOST_SEM_WRITTEN),
      .CORE_IRQ(CORE_IRQ), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ERASE(MEM_ERASE), .MEM_ADDR(MEM_ADDR),
      .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .FLASH_BUSY(FLASH_BUSY),
      .BUFFER_FULL(BUFFER_FULL), .ERASE_ERROR(ERASE_ERROR), .PROGRAM_ERROR(PROGRAM_ERROR));
   flash_port_model u_mem (.clk(CLOCK), .rst(RST), .req(MEM_REQ), .we(MEM_WRITE), .erase(MEM_ERASE),
      .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .rdata(MEM_RDATA));
   initial forever #5 CLOCK = ~CLOCK;
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Address and data are offered together; the block takes both in one cycle.
   task wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge CLOCK);
      AWADDR <= a;
      WDATA <= v;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      do @(posedge CLOCK); while (AWREADY !== 1'b1 || WREADY !== 1'b1);
      AWVALID <= 1'b0;
      WVALID <= 1'b0;
      while (BVALID !== 1'b1) @(posedge CLOCK);
      r = BRESP;
      BREADY <= 1'b0;
   endtask
   task rchk(input logic [31:0] a, input logic [31:0] e);
      @(posedge CLOCK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do @(posedge CLOCK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      while (RVALID !== 1'b1) @(posedge CLOCK);
      d = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
      chk(d, e);
   endtask
   task t_reset;
      rchk(32'h14, 32'h0);
      rchk(32'h18, 32'h0);
      rchk(32'h30, 32'h0);
      $display("reset values done");
   endtask
   task t_indirect;
      for (int i = 0; i < 4; i++) wr(32'(4 * i), 32'(8'h11 * (i + 1)));
      rchk(32'hC, 32'h44);
      wr(32'h10, 32'h5A);
      chk(u_mem.last_addr, 32'h44332211);
      chk(u_mem.last_data, 32'h5A);
      u_mem.delay = 3;
      rchk(32'h10, 32'hB4);
      $display("indirect access done");
   endtask
   task t_erase;
      wr(32'h14, 32'hFF);
      rchk(32'h14, 32'h20);
      wr(32'h10, 32'h00);
      chk(u_mem.last_erase, 32'h1);
      wr(32'h14, 32'h00);
      wr(32'h10, 32'h01);
      chk(u_mem.last_erase, 32'h0);
      $display("page erase done");
   endtask
   task t_status;
      int n;
      @(posedge CLOCK);
      ERASE_ERROR <= 1'b1;
      PROGRAM_ERROR <= 1'b1;
      FLASH_BUSY <= 1'b1;
      BUFFER_FULL <= 1'b1;
      @(posedge CLOCK);
      ERASE_ERROR <= 1'b0;
      PROGRAM_ERROR <= 1'b0;
      rchk(32'h18, 32'h0F);
      n = u_mem.n_wr;
      wr(32'h10, 32'h77);
      chk(u_mem.n_wr, n);
      rchk(32'h18, 32'h1F);
      wr(32'h18, 32'h13);
      rchk(32'h18, 32'h1F);
      FLASH_BUSY <= 1'b0;
      BUFFER_FULL <= 1'b0;
      wr(32'h18, 32'h01);
      rchk(32'h18, 32'h12);
      wr(32'h18, 32'h12);
      rchk(32'h18, 32'h00);
      $display("status flags done");
   endtask
   task t_sem;
      HOST_SEM_IRQ_ENABLE <= 1'b1;
      wr(32'h30, 32'hFA);
      chk(HOST_SEM_WRITTEN, 32'h1);
      chk(CORE_IRQ, 32'h1);
      @(posedge CLOCK);
      CORE_SEM_WE <= 1'b1;
      CORE_SEM_WDATA <= 4'h5;
      CORE_SEM_FLAG_CLR <= 1'b1;
      @(posedge CLOCK);
      CORE_SEM_WE <= 1'b0;
      CORE_SEM_FLAG_CLR <= 1'b0;
      rchk(32'h30, 32'h5A);
      chk(HOST_SEM_WRITTEN, 32'h0);
      wr(32'h24, 32'h1);
      chk(r, 32'h2);
      rchk(32'h24, 32'h0);
      chk(r, 32'h2);
      rchk(32'h31, 32'h0);
      chk(r, 32'h2);
      $display("semaphore and decode done");
   endtask
   // Control, status and semaphore are made non-zero first, so a reset that misses them shows.
   task t_midreset;
      wr(32'h14, 32'h20);
      wr(32'h30, 32'h03);
      chk(CORE_IRQ, 32'h1);
      @(posedge CLOCK);
      ERASE_ERROR <= 1'b1;
      @(posedge CLOCK);
      ERASE_ERROR <= 1'b0;
      rchk(32'h18, 32'h01);
      RST <= 1'b1;
      repeat (3) @(posedge CLOCK);
      RST <= 1'b0;
      rchk(32'h14, 32'h0);
      rchk(32'h18, 32'h0);
      rchk(32'h30, 32'h0);
      chk(HOST_SEM_WRITTEN, 32'h0);
      chk(CORE_IRQ, 32'h0);
      $display("mid-run reset done");
   endtask
   task finish_test;
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge CLOCK);
      RST <= 1'b0;
      t_reset();
      t_indirect();
      t_erase();
      t_status();
      t_sem();
      t_midreset();
      finish_test();
   end
   initial
   begin
      repeat (5000) @(posedge CLOCK);
      err_count++;
      finish_test();
   end
endmodule
